// file: hw/cia_event_reg.sv
// Purpose: Sticky event status with mask and one level interrupt
// Assumes: Write-one-to-clear, set wins over clear
// Notes:   Width is a parameter
`timescale 1ns/1ps
`default_nettype none
module cia_event_reg
  import cia_pkg::*;
#(
  parameter int W = 2
) (
  input  wire logic         ref_clk,
  input  wire logic         sys_rst,
  input  wire logic [W-1:0] evtSet,
  input  wire logic [W-1:0] clrOnes,
  input  wire logic         clrWr,
  input  wire logic [W-1:0] maskData,
  input  wire logic         maskWr,
  output logic      [W-1:0] status,
  output logic      [W-1:0] mask,
  output logic              irqOut
);
  // Elaboration-time refusal of an empty event vector
  if (W < 1) begin : gBadWidth
    $error("cia_event_reg: W must be at least 1");
  end

  logic [W-1:0] stat_q;
  logic [W-1:0] mask_q;
  wire  [W-1:0] stat_d = evtSet | (stat_q & ~(clrWr ? clrOnes : {W{1'b0}}));

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      stat_q <= '0;
      mask_q <= W'(CIA_RST_MASK);
    end else begin
      stat_q <= stat_d;
      if (maskWr) mask_q <= maskData;
    end
  end

  assign status = stat_q;
  assign mask   = mask_q;
  assign irqOut = |(stat_q & mask_q);
endmodule
`default_nettype wire

// file: hw/cia_top.sv
// Purpose: Interrupt enables, counter latch and entry selection
// Assumes: Instruction strobes are one-cycle pulses from the decoder
// Notes:   Software view over APB; irq is the masked sticky event level
`timescale 1ns/1ps
`default_nettype none
module cia_top
  import cia_pkg::*;
(
  input  wire logic                  ref_clk,
  input  wire logic                  sys_rst,
  // Processor side
  input  wire cia_instr_t            instr,
  input  wire logic                  extIrqIn,
  input  wire logic                  ctrUnderflow,
  input  wire logic                  pulseMeasureEnd,
  input  wire logic                  pulseWidthMeasureMode,
  input  wire logic                  masterIrqEnable,
  input  wire logic                  instrBoundary,
  input  wire cia_sel_t              curSel,
  output logic                       irqRequest,
  output logic                       irqAccept,
  output logic                       branchOnCntIrqTaken,
  output cia_sel_t                   newSel,
  output logic                       newSelValid,
  output logic [7:0]                 savedContext,
  // APB
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [CIA_ADDR_W-1:0] paddr,
  input  wire logic [31:0]           pwdata,
  output logic [31:0]                prdata,
  output logic                       pready,
  output logic                       pslverr,
  output logic                       irq
);
  logic       extEn_q;
  logic       cntEn_q;
  logic       cntLatch_q;
  cia_sel_t   saved_q;
  cia_sel_t   newSel_q;
  logic       newSelValid_q;
  logic       accept_q;
  logic [31:0] prdata_q;
  cia_state_t state_q;

  // APB decode
  wire apbAcc    = psel & penable;
  wire apbWr     = apbAcc & pwrite;
  wire hitCtrl   = paddr == CIA_OFF_CTRL;
  wire hitStatus = paddr == CIA_OFF_STATUS;
  wire hitIrqSt  = paddr == CIA_OFF_IRQST;
  wire hitIrqMsk = paddr == CIA_OFF_IRQMSK;
  wire hitCtx    = paddr == CIA_OFF_CONTEXT;
  wire hitAny    = hitCtrl | hitStatus | hitIrqSt | hitIrqMsk | hitCtx;
  wire ctrlWr    = apbWr & hitCtrl;

  // Software writes to CTRL act like the enable instructions
  wire swXSet = ctrlWr & pwdata[CIA_BIT_XEN];
  wire swXClr = ctrlWr & ~pwdata[CIA_BIT_XEN];
  wire swCSet = ctrlWr & pwdata[CIA_BIT_CEN];
  wire swCClr = ctrlWr & ~pwdata[CIA_BIT_CEN];

  wire extEn_d = (instr.extEnableSet | swXSet) ? 1'b1 :
                 (instr.extEnableClr | swXClr) ? 1'b0 : extEn_q;
  wire cntEn_d = (instr.cntEnableSet | swCSet) ? 1'b1 :
                 (instr.cntEnableClr | swCClr) ? 1'b0 : cntEn_q;

  // Latch set sources
  wire latchSet = ctrUnderflow | (pulseWidthMeasureMode & pulseMeasureEnd);
  wire bciTake  = instr.branchOnCnt & cntLatch_q;
  wire latchClr = bciTake | instr.loadCounter;
  // Set wins over clear so no event is lost
  wire cntLatch_d = latchSet ? 1'b1 : (latchClr ? 1'b0 : cntLatch_q);

  // External request follows the pin level
  wire extReq = extIrqIn & extEn_q;
  wire cntReq = cntLatch_q & cntEn_q;
  wire anyReq = extReq | cntReq;
  wire takeIrq = anyReq & masterIrqEnable & instrBoundary & (state_q == CiaIdle);

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      extEn_q    <= CIA_RST_EN;
      cntEn_q    <= CIA_RST_EN;
      cntLatch_q <= CIA_RST_LAT;
    end else begin
      extEn_q    <= extEn_d;
      cntEn_q    <= cntEn_d;
      // Interrupt entry does not touch enables or latch
      cntLatch_q <= cntLatch_d;
    end
  end

  // Entry sequencing: save selectors, then switch to R(1)/R(2)
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_q       <= CiaIdle;
      saved_q       <= '0;
      newSel_q      <= '0;
      newSelValid_q <= 1'b0;
      accept_q      <= 1'b0;
    end else begin
      accept_q      <= takeIrq;
      newSelValid_q <= 1'b0;
      case (state_q)
        CiaIdle: begin
          if (takeIrq) begin
            saved_q <= curSel;
            state_q <= CiaEntry;
          end
        end
        CiaEntry: begin
          newSel_q.pcSel <= CIA_PC_SEL_IRQ;
          newSel_q.spSel <= CIA_SP_SEL_IRQ;
          newSelValid_q  <= 1'b1;
          state_q        <= CiaIdle;
        end
        default: state_q <= CiaIdle;
      endcase
    end
  end

  // Sticky events: interrupt entry and counter latch set
  logic [CIA_EV_W-1:0] evStatus;
  logic [CIA_EV_W-1:0] evMask;
  wire  [CIA_EV_W-1:0] evSet;
  assign evSet[CIA_EV_ENTRY] = takeIrq;
  assign evSet[CIA_EV_LATCH] = latchSet;

  cia_event_reg #(
    .W(CIA_EV_W)
  ) cia_event_reg_i (
    .ref_clk  (ref_clk),
    .sys_rst  (sys_rst),
    .evtSet   (evSet),
    .clrOnes  (pwdata[CIA_EV_W-1:0]),
    .clrWr    (apbWr & hitIrqSt),
    .maskData (pwdata[CIA_EV_W-1:0]),
    .maskWr   (apbWr & hitIrqMsk),
    .status   (evStatus),
    .mask     (evMask),
    .irqOut   (irq)
  );

  // Read mux
  wire [31:0] rdCtrl   = {29'h0, masterIrqEnable, cntEn_q, extEn_q};
  wire [31:0] rdStatus = {27'h0, extIrqIn, cntLatch_q, masterIrqEnable, cntEn_q, extEn_q};
  wire [31:0] rdIrqSt  = {{(32-CIA_EV_W){1'b0}}, evStatus};
  wire [31:0] rdIrqMsk = {{(32-CIA_EV_W){1'b0}}, evMask};
  wire [31:0] rdCtx    = {24'h0, saved_q};
  wire [31:0] rdMux    = hitCtrl   ? rdCtrl   :
                         hitStatus ? rdStatus :
                         hitIrqSt  ? rdIrqSt  :
                         hitIrqMsk ? rdIrqMsk :
                         hitCtx    ? rdCtx    : 32'h0;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) prdata_q <= 32'h0;
    else if (psel & ~penable & ~pwrite) prdata_q <= rdMux;
  end

  assign prdata              = prdata_q;
  assign pready              = 1'b1;
  assign pslverr             = apbAcc & ~hitAny;
  assign irqRequest          = anyReq & masterIrqEnable;
  assign irqAccept           = accept_q;
  assign branchOnCntIrqTaken = bciTake;
  assign newSel              = newSel_q;
  assign newSelValid         = newSelValid_q;
  assign savedContext        = saved_q;
endmodule
`default_nettype wire

// file: include/cia_pkg.sv
// Purpose: Constants and types for the counter interrupt arbiter
// Assumes: One clock, synchronous active-high reset
// Notes:   Register map over APB, one aligned word each
//
// Functional notes
// - Reset sets both the external and the counter interrupt enables.
// - Reset clears the pending counter interrupt latch.
// - Four instructions each set or clear exactly one of the two enables.
// - External request is not stored; it follows the input level.
// - Counter underflow, or pulse-measure end in pulse width measure mode, sets the counter latch.
// - Branch-on-counter-interrupt is taken when the latch is set.
// - Taking an interrupt leaves enables and latch untouched.
// - Branch-on-counter-interrupt that finds the latch set clears it.
// - Load-counter instruction clears the counter latch.
// - Interrupt entry saves selectors, selects R(1) as PC, R(2) as SP.
package cia_pkg;

  localparam int          CIA_ADDR_W      = 12;
  localparam logic [11:0] CIA_OFF_CTRL    = 12'h000;
  localparam logic [11:0] CIA_OFF_STATUS  = 12'h004;
  localparam logic [11:0] CIA_OFF_IRQST   = 12'h008;
  localparam logic [11:0] CIA_OFF_IRQMSK  = 12'h00c;
  localparam logic [11:0] CIA_OFF_CONTEXT = 12'h010;

  // Control / status bit positions
  localparam int CIA_BIT_XEN  = 0;
  localparam int CIA_BIT_CEN  = 1;
  localparam int CIA_BIT_MIE  = 2;
  localparam int CIA_BIT_LAT  = 3;
  localparam int CIA_BIT_XREQ = 4;

  // Event bit positions
  localparam int CIA_EV_ENTRY = 0;
  localparam int CIA_EV_LATCH = 1;
  localparam int CIA_EV_W     = 2;

  localparam logic [3:0] CIA_PC_SEL_IRQ = 4'h1;
  localparam logic [3:0] CIA_SP_SEL_IRQ = 4'h2;
  localparam logic       CIA_RST_EN     = 1'b1;
  localparam logic       CIA_RST_LAT    = 1'b0;
  localparam logic [1:0] CIA_RST_MASK   = 2'h0;

  typedef struct packed {
    logic extEnableSet;
    logic extEnableClr;
    logic cntEnableSet;
    logic cntEnableClr;
    logic branchOnCnt;
    logic loadCounter;
  } cia_instr_t;

  typedef struct packed {
    logic [3:0] pcSel;
    logic [3:0] spSel;
  } cia_sel_t;

  typedef enum logic [1:0] {CiaIdle, CiaEntry} cia_state_t;

endpackage

// file: tb/cia_src_model.sv
// Purpose: Timer-counter event source facing the arbiter
// Assumes: Go strobes last one cycle
// Notes:   Emits one-cycle registered pulses
`timescale 1ns/1ps
`default_nettype none
module cia_src_model (
  input  wire logic ref_clk,
  input  wire logic ufGo,
  input  wire logic peGo,
  output var  logic ctrUnderflow,
  output var  logic pulseMeasureEnd
);
  always @(posedge ref_clk) begin
    ctrUnderflow    <= ufGo;
    pulseMeasureEnd <= peGo;
  end
endmodule
`default_nettype wire

// file: tb/cia_top_chk.sv
// Purpose: Port-level checks of the arbiter
// Assumes: Single clock domain
// Notes:   Bound to cia_top
`timescale 1ns/1ps
`default_nettype none
module cia_top_chk
  import cia_pkg::*;
(
  input wire logic       ref_clk,
  input wire logic       sys_rst,
  input wire cia_instr_t instr,
  input wire logic       extIrqIn,
  input wire logic       ctrUnderflow,
  input wire logic       pulseMeasureEnd,
  input wire logic       pulseWidthMeasureMode,
  input wire logic       masterIrqEnable,
  input wire logic       instrBoundary,
  input wire cia_sel_t   curSel,
  input wire logic       irqRequest,
  input wire logic       irqAccept,
  input wire logic       branchOnCntIrqTaken,
  input wire cia_sel_t   newSel,
  input wire logic       newSelValid,
  input wire logic [7:0] savedContext,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pslverr
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  logic setEv;
  assign setEv = ctrUnderflow | (pulseMeasureEnd & pulseWidthMeasureMode);
  property p_rst_en;
    $past(sys_rst) && extIrqIn && masterIrqEnable |-> irqRequest;
  endproperty
  a_rst_en: assert property (p_rst_en) else $error("enable not set by reset");
  property p_rst_lat;
    $past(sys_rst) && !extIrqIn |-> !irqRequest;
  endproperty
  a_rst_lat: assert property (p_rst_lat) else $error("latch survives reset");
  property p_set;
    setEv ##1 instr.branchOnCnt |-> branchOnCntIrqTaken;
  endproperty
  a_set: assert property (p_set) else $error("latch not set");
  property p_bci_clr;
    instr.branchOnCnt && branchOnCntIrqTaken && !setEv ##1 instr.branchOnCnt
      |-> !branchOnCntIrqTaken;
  endproperty
  a_bci_clr: assert property (p_bci_clr) else $error("branch left latch");
  property p_ldc_clr;
    instr.loadCounter && !setEv ##1 instr.branchOnCnt |-> !branchOnCntIrqTaken;
  endproperty
  a_ldc_clr: assert property (p_ldc_clr) else $error("load left latch");
  property p_sel;
    irqAccept |=> newSelValid && newSel == {CIA_PC_SEL_IRQ, CIA_SP_SEL_IRQ};
  endproperty
  a_sel: assert property (p_sel) else $error("bad entry selectors");
  property p_ctx;
    irqAccept |-> savedContext == $past(curSel);
  endproperty
  a_ctx: assert property (p_ctx) else $error("bad saved context");
  property p_take;
    irqAccept |-> $past(irqRequest && instrBoundary);
  endproperty
  a_take: assert property (p_take) else $error("entry without cause");
  property p_mie;
    !masterIrqEnable |-> !irqRequest;
  endproperty
  a_mie: assert property (p_mie) else $error("request while disabled");
  property p_err;
    pslverr |-> psel && penable;
  endproperty
  a_err: assert property (p_err) else $error("error outside access");
endmodule
bind cia_top cia_top_chk cia_top_chk_i (.ref_clk, .sys_rst, .instr, .extIrqIn, .ctrUnderflow,
  .pulseMeasureEnd, .pulseWidthMeasureMode, .masterIrqEnable, .instrBoundary, .curSel,
  .irqRequest, .irqAccept, .branchOnCntIrqTaken, .newSel, .newSelValid, .savedContext,
  .psel, .penable, .pslverr);
`default_nettype wire

// file: tb/cia_top_tb.sv
// Purpose: Directed bench of the arbiter over APB and strobes
// Assumes: pready answers within 50 cycles
// Notes:   Checks STATUS bits, other registers and output strobes between steps
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin totalChecks++; if ((a) !== (b)) begin fails++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, a, b); end end
module cia_top_tb
  import cia_pkg::*;
;
  logic ref_clk = 0, sys_rst = 1, extIrqIn = 0, mode = 0, mie = 0, bnd = 0;
  logic psel = 0, penable = 0, pwrite = 0, ufGo = 0, peGo = 0, uf, pe;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, irq, irqReq, acc, tk, tk0, tk1, nsv, err;
  cia_instr_t instr = '0;
  cia_sel_t curSel = 8'h5a, newSel;
  logic [7:0] ctx;
  int fails = 0, totalChecks = 0;
  always #2 ref_clk = ~ref_clk;
  cia_src_model cia_src_model_i (.ref_clk, .ufGo, .peGo, .ctrUnderflow(uf), .pulseMeasureEnd(pe));
  cia_top cia_top_i (.ref_clk, .sys_rst, .instr, .extIrqIn, .ctrUnderflow(uf),
    .pulseMeasureEnd(pe), .pulseWidthMeasureMode(mode), .masterIrqEnable(mie),
    .instrBoundary(bnd), .curSel, .irqRequest(irqReq), .irqAccept(acc),
    .branchOnCntIrqTaken(tk), .newSel, .newSelValid(nsv), .savedContext(ctx),
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .irq);
  task end_of_test();
    $display("checks=%0d mismatches=%0d", totalChecks, fails);
    if (fails == 0 && totalChecks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge ref_clk);
    penable <= 1;
    do begin @(posedge ref_clk); n++; end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      fails++;
      end_of_test();
    end else begin
      rd = prdata;
      err = pslverr;
      {psel, penable} <= 2'b00;
    end
  endtask
  task st(input logic [31:0] e);
    apb(1'b0, CIA_OFF_STATUS, '0);
    `CHK(rd, e)
  endtask
  task ins(input logic [5:0] v0, input logic [5:0] v1);
    @(posedge ref_clk) instr <= v0;
    @(negedge ref_clk) tk0 = tk;
    @(posedge ref_clk) instr <= v1;
    @(negedge ref_clk) tk1 = tk;
    @(posedge ref_clk) instr <= '0;
  endtask
  task go(input logic u);
    @(posedge ref_clk) {ufGo, peGo} <= {u, !u};
    @(posedge ref_clk) {ufGo, peGo} <= 2'b00;
  endtask
  // Mid-run reset with masterIrqEnable active and extIrqIn driven from x
  task rst(input logic x);
    @(posedge ref_clk) {sys_rst, extIrqIn, mie} <= {1'b1, x, 1'b1};
    repeat (4) @(posedge ref_clk);
    sys_rst <= 0;
  endtask
  initial begin
    repeat (4) @(posedge ref_clk);
    sys_rst <= 0;
    st(32'h3);
    ins(6'h10, 6'h00); st(32'h2);
    ins(6'h04, 6'h00); st(32'h0);
    ins(6'h20, 6'h00); st(32'h1);
    ins(6'h08, 6'h00); st(32'h3);
    apb(1'b1, CIA_OFF_CTRL, 32'h2); st(32'h2);
    apb(1'b1, CIA_OFF_CTRL, 32'h1); st(32'h1);
    apb(1'b1, CIA_OFF_CTRL, 32'h3); apb(1'b0, CIA_OFF_CTRL, '0); `CHK(rd, 32'h3)
    $display("enables done");
    @(posedge ref_clk) {extIrqIn, mie} <= 2'b11;
    @(negedge ref_clk) `CHK(irqReq, 1'b1)
    st(32'h17);
    @(posedge ref_clk) extIrqIn <= 0;
    @(negedge ref_clk) `CHK(irqReq, 1'b0)
    @(posedge ref_clk) mie <= 0;
    go(1'b1); ins(6'h02, 6'h02); `CHK({tk0, tk1}, 2'b10)
    go(1'b0); ins(6'h02, 6'h00); `CHK(tk0, 1'b0)
    mode <= 1;
    go(1'b0); st(32'hb);
    ins(6'h01, 6'h02); `CHK(tk1, 1'b0)
    st(32'h3);
    apb(1'b1, CIA_OFF_IRQST, 32'h3);
    apb(1'b1, CIA_OFF_IRQMSK, 32'h3);
    go(1'b1);
    @(posedge ref_clk) {mie, bnd} <= 2'b11;
    @(negedge ref_clk) `CHK(irq, 1'b1)
    repeat (10) begin @(negedge ref_clk); if (acc === 1'b1) break; end
    if (acc !== 1'b1) begin fails++; end_of_test(); end
    `CHK(acc, 1'b1)
    `CHK(ctx, 8'h5a)
    @(posedge ref_clk) {mie, bnd} <= 2'b00;
    @(negedge ref_clk) `CHK({nsv, newSel}, {1'b1, CIA_PC_SEL_IRQ, CIA_SP_SEL_IRQ})
    st(32'hb);
    apb(1'b0, CIA_OFF_IRQST, '0); `CHK(rd, 32'h3)
    apb(1'b0, CIA_OFF_CONTEXT, '0); `CHK(rd, 32'h5a)
    apb(1'b0, CIA_OFF_IRQMSK, '0); `CHK(rd, 32'h3)
    apb(1'b1, CIA_OFF_IRQST, 32'h3);
    @(negedge ref_clk) `CHK(irq, 1'b0)
    apb(1'b0, 12'h100, '0); `CHK({err, rd}, {1'b1, 32'h0})
    $display("latch and entry done");
    ins(6'h10, 6'h04); rst(1'b0); st(32'h7);
    go(1'b1); ins(6'h10, 6'h04); rst(1'b1); st(32'h17);
    apb(1'b0, CIA_OFF_IRQMSK, '0); `CHK(rd, 32'h0)
    $display("reset done");
    end_of_test();
  end
endmodule
`default_nettype wire
